// file: verilog/brk_pkg.sv
// Purpose: constants, field layout and helpers of the compound break comparator
// Assumes: 32-bit AHB-Lite register words, one word per register
// Notes: byte offsets below are the register addresses
//
// What this block does
// - break only when program counter, RAM access and registers all match together
// - arming the compound condition disarms independent address, data and register breaks
// - arming any independent break afterwards disarms the compound condition
// - the clear command disarms the compound condition until it is armed again
// - exactly one compound condition exists; programming it again replaces it
// - every register or flag term has a mask; a masked term always matches
// - compare RAM address, data, direction, A, B, X, Y and four flags at the PC
package brk_pkg;
	localparam int PC_W = 12;
	localparam int XY_W = 12;
	localparam int DEF_SEL = 1;
	// register byte offsets
	localparam logic [7:0] CMD_OFS = 8'h00;
	localparam logic [7:0] PC_OFS = 8'h04;
	localparam logic [7:0] MEM_OFS = 8'h08;
	localparam logic [7:0] AB_OFS = 8'h0c;
	localparam logic [7:0] XY_OFS = 8'h10;
	localparam logic [7:0] STAT_OFS = 8'h14;
	localparam logic [7:0] IRQ_STAT_OFS = 8'h18;
	localparam logic [7:0] IRQ_MASK_OFS = 8'h1c;
	// command register bits (write-only pulses)
	localparam int CMD_SET = 0;
	localparam int CMD_CLR = 1;
	localparam int CMD_ADDR_SET = 2;
	localparam int CMD_DATA_SET = 3;
	localparam int CMD_REG_SET = 4;
	localparam int CMD_RESUME = 5;
	localparam int CMD_INDEP_CLR = 6;
	// memory access condition word
	localparam int MEM_ADDR_LSB = 0;
	localparam int MEM_DATA_LSB = 12;
	localparam int MEM_WR_BIT = 16;
	localparam int MEM_ADDR_MSK = 17;
	localparam int MEM_DATA_MSK = 18;
	localparam int MEM_WR_MSK = 19;
	// register and flag condition word
	localparam int A_LSB = 0;
	localparam int B_LSB = 4;
	localparam int INTF_BIT = 8;
	localparam int DECF_BIT = 9;
	localparam int ZEROF_BIT = 10;
	localparam int CARRYF_BIT = 11;
	localparam int A_MSK = 16;
	localparam int B_MSK = 17;
	localparam int INTF_MSK = 18;
	localparam int DECF_MSK = 19;
	localparam int ZEROF_MSK = 20;
	localparam int CARRYF_MSK = 21;
	// index register condition word
	localparam int X_LSB = 0;
	localparam int Y_LSB = 12;
	localparam int X_MSK = 24;
	localparam int Y_MSK = 25;
	// status bits
	localparam int ST_ARMED = 0;
	localparam int ST_INDEP_LSB = 1;
	localparam int ST_HALT = 4;
	// implemented bits and reset values (every term except the PC masked at reset)
	localparam logic [31:0] PC_USED = 32'h0000_0fff;
	localparam logic [31:0] MEM_USED = 32'h000f_ffff;
	localparam logic [31:0] AB_USED = 32'h003f_0fff;
	localparam logic [31:0] XY_USED = 32'h03ff_ffff;
	localparam logic [31:0] PC_RST = 32'h0000_0000;
	localparam logic [31:0] MEM_RST = 32'h000e_0000;
	localparam logic [31:0] AB_RST = 32'h003f_0000;
	localparam logic [31:0] XY_RST = 32'h0300_0000;
	localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WR = 2'b01,
		BUS_RD = 2'b10
	} bus_state_t;

	// masked equality: a masked term always matches
	function automatic logic meq(input logic [11:0] v, input logic [11:0] c, input logic m);
		meq = m | (v == c);
	endfunction
endpackage

// file: verilog/reg_if.sv
// Purpose: register access path between bus slave and comparator core
// Assumes: single clock, write strobe valid for one cycle
// Notes: rdata is combinational from the core
`timescale 1ns/10ps
`default_nettype none
interface reg_if;
	logic wr;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	modport bus (output wr, output addr, output wdata, input rdata);
	modport core (input wr, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: verilog/ahb_slave.sv
// Purpose: AHB-Lite slave front end for the register file
// Assumes: single word transfers, response always OKAY
// Notes: writes have no wait state, reads have one
`timescale 1ns/10ps
`default_nettype none
module ahb_slave (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// register side
	reg_if.bus rb
);
	brk_pkg::bus_state_t state_ff;
	logic [7:0] addr_ff;
	logic hreadyout_ff;
	logic [31:0] hrdata_ff;
	logic take;

	assign take = hready & hsel & htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= brk_pkg::BUS_IDLE;
			addr_ff <= 8'h00;
		end else if (take) begin
			state_ff <= hwrite ? brk_pkg::BUS_WR : brk_pkg::BUS_RD;
			addr_ff <= haddr[7:0];
		end else begin
			state_ff <= brk_pkg::BUS_IDLE;
		end
	end

	// a read holds hready low one cycle while the read data is registered into hrdata
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_ff <= 1'b1;
		end else begin
			hreadyout_ff <= !(take && !hwrite);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (state_ff == brk_pkg::BUS_RD) begin
			hrdata_ff <= rb.rdata;
		end
	end

	assign rb.wr = (state_ff == brk_pkg::BUS_WR);
	assign rb.addr = addr_ff;
	assign rb.wdata = hwdata;
	assign hreadyout = hreadyout_ff;
	assign hrdata = hrdata_ff;
	assign hresp = 1'b0;

	read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read did not take exactly one wait state");
endmodule
`default_nettype wire

// file: verilog/match_unit.sv
// Purpose: combinational compare of the target state against the compound condition
// Assumes: target signals are on hclk
// Notes: memory terms need a RAM access unless all of them are masked
`timescale 1ns/10ps
`default_nettype none
module match_unit (
	// clock and reset, for checks only
	input wire logic hclk,
	input wire logic hresetn,
	// programmed condition
	input wire logic [31:0] pc_cond,
	input wire logic [31:0] mem_cond,
	input wire logic [31:0] ab_cond,
	input wire logic [31:0] xy_cond,
	// target state
	input wire logic exec_valid,
	input wire logic [11:0] pc,
	input wire logic ram_valid,
	input wire logic [11:0] ram_addr,
	input wire logic [3:0] ram_data,
	input wire logic ram_write,
	input wire logic [3:0] reg_a,
	input wire logic [3:0] reg_b,
	input wire logic [11:0] reg_x,
	input wire logic [11:0] reg_y,
	input wire logic interrupt_flag,
	input wire logic decimal_flag,
	input wire logic zero_flag,
	input wire logic carry_flag,
	// result
	output logic hit
);
	logic pc_ok;
	logic mem_ok;
	logic mem_all_masked;
	logic reg_ok;

	assign pc_ok = exec_valid && (pc == pc_cond[11:0]);
	assign mem_all_masked = mem_cond[brk_pkg::MEM_ADDR_MSK] & mem_cond[brk_pkg::MEM_DATA_MSK]
		& mem_cond[brk_pkg::MEM_WR_MSK];
	assign mem_ok = mem_all_masked | (ram_valid
		& brk_pkg::meq(ram_addr, mem_cond[11:0], mem_cond[brk_pkg::MEM_ADDR_MSK])
		& brk_pkg::meq({8'h00, ram_data}, {8'h00, mem_cond[15:12]},
			mem_cond[brk_pkg::MEM_DATA_MSK])
		& brk_pkg::meq({11'h000, ram_write}, {11'h000, mem_cond[brk_pkg::MEM_WR_BIT]},
			mem_cond[brk_pkg::MEM_WR_MSK]));
	assign reg_ok = brk_pkg::meq({8'h00, reg_a}, {8'h00, ab_cond[3:0]}, ab_cond[brk_pkg::A_MSK])
		& brk_pkg::meq({8'h00, reg_b}, {8'h00, ab_cond[7:4]}, ab_cond[brk_pkg::B_MSK])
		& brk_pkg::meq({11'h000, interrupt_flag}, {11'h000, ab_cond[brk_pkg::INTF_BIT]},
			ab_cond[brk_pkg::INTF_MSK])
		& brk_pkg::meq({11'h000, decimal_flag}, {11'h000, ab_cond[brk_pkg::DECF_BIT]},
			ab_cond[brk_pkg::DECF_MSK])
		& brk_pkg::meq({11'h000, zero_flag}, {11'h000, ab_cond[brk_pkg::ZEROF_BIT]},
			ab_cond[brk_pkg::ZEROF_MSK])
		& brk_pkg::meq({11'h000, carry_flag}, {11'h000, ab_cond[brk_pkg::CARRYF_BIT]},
			ab_cond[brk_pkg::CARRYF_MSK])
		& brk_pkg::meq(reg_x, xy_cond[11:0], xy_cond[brk_pkg::X_MSK])
		& brk_pkg::meq(reg_y, xy_cond[23:12], xy_cond[brk_pkg::Y_MSK]);
	assign hit = pc_ok & mem_ok & reg_ok;

	single_point_a: assert property (@(posedge hclk) disable iff (!hresetn)
		hit |-> exec_valid && pc == pc_cond[11:0])
		else $error("hit away from the programmed address");
	unmasked_terms_a: assert property (@(posedge hclk) disable iff (!hresetn)
		hit |-> (ab_cond[brk_pkg::A_MSK] || reg_a == ab_cond[3:0])
			&& (xy_cond[brk_pkg::Y_MSK] || reg_y == xy_cond[23:12])
			&& (ab_cond[brk_pkg::CARRYF_MSK] || carry_flag == ab_cond[brk_pkg::CARRYF_BIT]))
		else $error("hit with an unmasked term differing");
	masked_terms_a: assert property (@(posedge hclk) disable iff (!hresetn)
		pc_ok && mem_all_masked && (&ab_cond[21:16]) && (&xy_cond[25:24]) |-> hit)
		else $error("fully masked condition did not hit");
endmodule
`default_nettype wire

// file: verilog/compound_break_comparator.sv
// Purpose: compound break condition of an in-circuit emulator with AHB-Lite registers
// Assumes: target core signals arrive on hclk; independent break units sit outside
// Notes: a break halts the target until software writes the resume command
//
// Design decisions made here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module compound_break_comparator (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// target execution state
	input wire logic exec_valid,
	input wire logic [11:0] pc,
	input wire logic ram_valid,
	input wire logic [11:0] ram_addr,
	input wire logic [3:0] ram_data,
	input wire logic ram_write,
	input wire logic [3:0] reg_a,
	input wire logic [3:0] reg_b,
	input wire logic [11:0] reg_x,
	input wire logic [11:0] reg_y,
	input wire logic interrupt_flag,
	input wire logic decimal_flag,
	input wire logic zero_flag,
	input wire logic carry_flag,
	// break control
	output logic cpu_halt,
	output logic break_event,
	output logic addr_break_armed,
	output logic data_access_break_armed,
	output logic register_break_armed,
	output logic irq
);
	reg_if rb ();

	logic [31:0] pc_ff;
	logic [31:0] mem_ff;
	logic [31:0] ab_ff;
	logic [31:0] xy_ff;
	logic armed_ff;
	logic [2:0] indep_ff;
	logic halt_ff;
	logic event_ff;
	logic stat_ff;
	logic mask_ff;
	logic irq_ff;
	logic nxt_stat;
	logic hit;
	logic fire;
	logic cmd_wr;
	logic [31:0] cmd;
	logic compound_break_set;
	logic compound_break_clear;
	logic [2:0] indep_set;
	logic [31:0] rdata;

	ahb_slave u_slave (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hwdata(hwdata),
		.hready(hready),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.rb(rb.bus)
	);

	match_unit u_match (
		.hclk(hclk),
		.hresetn(hresetn),
		.pc_cond(pc_ff),
		.mem_cond(mem_ff),
		.ab_cond(ab_ff),
		.xy_cond(xy_ff),
		.exec_valid(exec_valid),
		.pc(pc),
		.ram_valid(ram_valid),
		.ram_addr(ram_addr),
		.ram_data(ram_data),
		.ram_write(ram_write),
		.reg_a(reg_a),
		.reg_b(reg_b),
		.reg_x(reg_x),
		.reg_y(reg_y),
		.interrupt_flag(interrupt_flag),
		.decimal_flag(decimal_flag),
		.zero_flag(zero_flag),
		.carry_flag(carry_flag),
		.hit(hit)
	);

	// command decode
	assign cmd_wr = rb.wr && (rb.addr == brk_pkg::CMD_OFS);
	assign cmd = rb.wdata;
	assign compound_break_set = cmd_wr && cmd[brk_pkg::CMD_SET];
	assign compound_break_clear = cmd_wr && cmd[brk_pkg::CMD_CLR];
	assign indep_set = cmd_wr ? {cmd[brk_pkg::CMD_REG_SET], cmd[brk_pkg::CMD_DATA_SET],
		cmd[brk_pkg::CMD_ADDR_SET]} : 3'b000;

	// condition words; a new write simply overwrites the single condition
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_ff <= brk_pkg::PC_RST;
			mem_ff <= brk_pkg::MEM_RST;
			ab_ff <= brk_pkg::AB_RST;
			xy_ff <= brk_pkg::XY_RST;
		end else if (rb.wr) begin
			if (rb.addr == brk_pkg::PC_OFS) begin
				pc_ff <= rb.wdata & brk_pkg::PC_USED;
			end else if (rb.addr == brk_pkg::MEM_OFS) begin
				mem_ff <= rb.wdata & brk_pkg::MEM_USED;
			end else if (rb.addr == brk_pkg::AB_OFS) begin
				ab_ff <= rb.wdata & brk_pkg::AB_USED;
			end else if (rb.addr == brk_pkg::XY_OFS) begin
				xy_ff <= rb.wdata & brk_pkg::XY_USED;
			end
		end
	end

	// compound arm state; set takes priority over clear and independent sets
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			armed_ff <= 1'b0;
		end else if (compound_break_set) begin
			armed_ff <= 1'b1;
		end else if (compound_break_clear) begin
			armed_ff <= 1'b0;
		end else if (|indep_set) begin
			armed_ff <= 1'b0;
		end
	end

	// independent break arms, handed to the outside break units
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			indep_ff <= 3'b000;
		end else if (compound_break_set) begin
			indep_ff <= 3'b000;
		end else if (cmd_wr) begin
			indep_ff <= (indep_ff & ~{3{cmd[brk_pkg::CMD_INDEP_CLR]}}) | indep_set;
		end
	end

	// halt and break event
	assign fire = armed_ff && hit && !halt_ff;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			halt_ff <= 1'b0;
			event_ff <= 1'b0;
		end else begin
			event_ff <= fire;
			if (fire) begin
				halt_ff <= 1'b1;
			end else if (cmd_wr && cmd[brk_pkg::CMD_RESUME]) begin
				halt_ff <= 1'b0;
			end
		end
	end

	// interrupt status, write one to clear; a new event wins over the clear
	assign nxt_stat = fire | (stat_ff & !(rb.wr && rb.addr == brk_pkg::IRQ_STAT_OFS
		&& rb.wdata[0]));
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			stat_ff <= nxt_stat;
			irq_ff <= nxt_stat & mask_ff;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask_ff <= brk_pkg::IRQ_MASK_RST[0];
		end else if (rb.wr && rb.addr == brk_pkg::IRQ_MASK_OFS) begin
			mask_ff <= rb.wdata[0];
		end
	end

	// read back; unmapped and reserved bits read zero
	always_comb begin
		rdata = 32'h0000_0000;
		if (rb.addr == brk_pkg::PC_OFS) begin
			rdata = pc_ff;
		end else if (rb.addr == brk_pkg::MEM_OFS) begin
			rdata = mem_ff;
		end else if (rb.addr == brk_pkg::AB_OFS) begin
			rdata = ab_ff;
		end else if (rb.addr == brk_pkg::XY_OFS) begin
			rdata = xy_ff;
		end else if (rb.addr == brk_pkg::STAT_OFS) begin
			rdata[brk_pkg::ST_ARMED] = armed_ff;
			rdata[brk_pkg::ST_INDEP_LSB +: 3] = indep_ff;
			rdata[brk_pkg::ST_HALT] = halt_ff;
		end else if (rb.addr == brk_pkg::IRQ_STAT_OFS) begin
			rdata[0] = stat_ff;
		end else if (rb.addr == brk_pkg::IRQ_MASK_OFS) begin
			rdata[0] = mask_ff;
		end
	end
	assign rb.rdata = rdata;

	assign cpu_halt = halt_ff;
	assign break_event = event_ff;
	assign addr_break_armed = indep_ff[0];
	assign data_access_break_armed = indep_ff[1];
	assign register_break_armed = indep_ff[2];
	assign irq = irq_ff;

	fire_halt_a: assert property (@(posedge hclk) disable iff (!hresetn)
		armed_ff && hit && !halt_ff |=> cpu_halt && break_event ##1 !break_event)
		else $error("match did not halt with a one-cycle event");
	indep_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
		compound_break_set |=> armed_ff && indep_ff == 3'b000)
		else $error("independent breaks survived compound arm");
	compound_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
		armed_ff && !compound_break_set && (|indep_set) |=> !armed_ff)
		else $error("compound condition stayed armed");
	clear_disarm_a: assert property (@(posedge hclk) disable iff (!hresetn)
		compound_break_clear && !compound_break_set |=> !armed_ff)
		else $error("clear did not disarm");
	disarmed_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!armed_ff |=> !break_event)
		else $error("break while disarmed");
	irq_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
		break_event && mask_ff && $stable(mask_ff) |-> irq)
		else $error("unmasked break event raised no interrupt");
endmodule
`default_nettype wire

// file: test/target_model.sv
// Purpose: behavioural target core that presents one execution state per cycle
// Assumes: state vector order pc, ram addr, data, dir, valid, a, b, x, y, four flags
// Notes: idle lines show the inverse of the last value, changing every cycle
`timescale 1ns/10ps
`default_nettype none
module target_model (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// bench control
	input wire logic run,
	input wire logic [65:0] st,
	input wire logic cpu_halt,
	// target state
	output logic exec_valid,
	output logic [11:0] pc,
	output logic ram_valid,
	output logic [11:0] ram_addr,
	output logic [3:0] ram_data,
	output logic ram_write,
	output logic [3:0] reg_a,
	output logic [3:0] reg_b,
	output logic [11:0] reg_x,
	output logic [11:0] reg_y,
	output logic interrupt_flag,
	output logic decimal_flag,
	output logic zero_flag,
	output logic carry_flag
);
	logic [65:0] cur;
	logic rv_raw;
	assign {pc, ram_addr, ram_data, ram_write, rv_raw, reg_a, reg_b, reg_x, reg_y} = cur[65:4];
	assign {interrupt_flag, decimal_flag, zero_flag, carry_flag} = cur[3:0];
	assign ram_valid = rv_raw & exec_valid;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cur <= '0;
			exec_valid <= 1'b0;
		end else if (run && !cpu_halt) begin
			cur <= st;
			exec_valid <= 1'b1;
		end else begin
			cur <= ~cur;
			exec_valid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Purpose: self-checking bench of the compound break comparator
// Assumes: single AHB-Lite master, target model on the execution side
// Notes: each scenario is its own task
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
	logic [1:0] htrans = 2'b00;
	logic [65:0] st = '0;
	logic hreadyout, hresp, cpu_halt, break_event, irq, exec_valid, ram_valid, ram_write;
	logic addr_break_armed, data_access_break_armed, register_break_armed;
	logic interrupt_flag, decimal_flag, zero_flag, carry_flag;
	logic [31:0] hrdata;
	logic [11:0] pc, ram_addr, reg_x, reg_y;
	logic [3:0] ram_data, reg_a, reg_b;
	int err_count = 0, samples_checked = 0, ev_cnt = 0;
	// matching state: pc 100, write of a to 070, decimal and carry flags set, y 03e
	localparam logic [65:0] BASE = {12'h100, 12'h070, 4'ha, 2'b11, 8'h00, 12'h000, 12'h03e, 4'h5};
	localparam logic [65:0] TM [0:12] = '{66'h1 << 54, 66'h1 << 42, 66'h1 << 38, 66'h1 << 37,
		66'h1 << 36, 66'h1 << 4, 66'h4, 66'h1, 66'hf << 32, 66'hf << 28, 66'hfff << 16,
		66'h8, 66'h2};
	localparam logic [12:0] TE = 13'b1_1111_0000_0000;
	always #25 hclk = ~hclk;
	always @(posedge hclk) begin
		if (break_event === 1'b1) begin
			ev_cnt <= ev_cnt + 1;
		end
	end
	compound_break_comparator compound_break_comparator_i (.hclk, .hresetn, .hsel, .haddr,
		.htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
		.hrdata, .exec_valid, .pc, .ram_valid, .ram_addr, .ram_data, .ram_write, .reg_a, .reg_b,
		.reg_x, .reg_y, .interrupt_flag, .decimal_flag, .zero_flag, .carry_flag, .cpu_halt,
		.break_event, .addr_break_armed, .data_access_break_armed, .register_break_armed, .irq);
	target_model target_model_i (.hclk, .hresetn, .run, .st, .cpu_halt, .exec_valid, .pc,
		.ram_valid, .ram_addr, .ram_data, .ram_write, .reg_a, .reg_b, .reg_x, .reg_y,
		.interrupt_flag, .decimal_flag, .zero_flag, .carry_flag);
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	// every request starts right after a rising edge, never from a falling one
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do begin
			@(posedge hclk);
		end while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		do begin
			@(posedge hclk);
		end while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk($sformatf("read %h", a), e, q);
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic cmd(input int b);
		bus(1'b1, brk_pkg::CMD_OFS, 32'h1 << b);
	endtask
	task automatic run_vec(input logic [65:0] v, input logic e);
		int n;
		@(posedge hclk);
		n = ev_cnt;
		st <= v;
		run <= 1'b1;
		repeat (8) @(posedge hclk);
		run <= 1'b0;
		@(negedge hclk);
		chk("cpu_halt", {31'h0, e}, {31'h0, cpu_halt});
		chk("break pulses", 32'(n) + 32'(e), 32'(ev_cnt));
		if (e) begin
			chk("irq", 32'h1, {31'h0, irq});
			rdc(brk_pkg::STAT_OFS, 32'h11);
			rdc(brk_pkg::IRQ_STAT_OFS, 32'h1);
			bus(1'b1, brk_pkg::IRQ_STAT_OFS, 32'h1);
			cmd(brk_pkg::CMD_RESUME);
			repeat (2) @(negedge hclk);
			chk("irq cleared", 32'h0, {31'h0, irq});
			chk("halt released", 32'h0, {31'h0, cpu_halt});
		end
	endtask
	task automatic t_reset();
		logic [7:0] ad [0:8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
		logic [31:0] ex [0:8] = '{32'h0, 32'h0, 32'h000e_0000, 32'h003f_0000, 32'h0300_0000,
			32'h0, 32'h0, 32'h0, 32'h0};
		for (int i = 0; i < 9; i++) begin
			rdc(ad[i], ex[i]);
		end
		run_vec(BASE, 1'b0);
		run_vec(BASE ^ (66'h100 << 54), 1'b0);
	endtask
	task automatic t_program();
		bus(1'b1, brk_pkg::PC_OFS, 32'h100);
		bus(1'b1, brk_pkg::MEM_OFS, 32'h0001_a070);
		bus(1'b1, brk_pkg::AB_OFS, 32'h0017_0a00);
		bus(1'b1, brk_pkg::XY_OFS, 32'h0103_e000);
		bus(1'b1, brk_pkg::IRQ_MASK_OFS, 32'h1);
		cmd(brk_pkg::CMD_SET);
		rdc(brk_pkg::MEM_OFS, 32'h0001_a070);
		rdc(brk_pkg::STAT_OFS, 32'h1);
		run_vec(BASE, 1'b1);
	endtask
	task automatic t_terms();
		for (int i = 0; i < 13; i++) begin
			run_vec(BASE ^ TM[i], TE[i]);
		end
	endtask
	task automatic t_excl();
		for (int k = 2; k < 5; k++) begin
			cmd(k);
			cmd(brk_pkg::CMD_SET);
			@(negedge hclk);
			chk("indep after set", 32'h0, {29'h0, register_break_armed,
				data_access_break_armed, addr_break_armed});
			rdc(brk_pkg::STAT_OFS, 32'h1);
			cmd(k);
			rdc(brk_pkg::STAT_OFS, 32'h1 << (k - 1));
			run_vec(BASE, 1'b0);
			cmd(brk_pkg::CMD_SET);
		end
		cmd(brk_pkg::CMD_ADDR_SET);
		cmd(brk_pkg::CMD_DATA_SET);
		cmd(brk_pkg::CMD_INDEP_CLR);
		rdc(brk_pkg::STAT_OFS, 32'h0);
		cmd(brk_pkg::CMD_SET);
	endtask
	task automatic t_clear();
		cmd(brk_pkg::CMD_CLR);
		rdc(brk_pkg::STAT_OFS, 32'h0);
		run_vec(BASE, 1'b0);
		cmd(brk_pkg::CMD_SET);
		run_vec(BASE, 1'b1);
	endtask
	task automatic t_replace();
		bus(1'b1, brk_pkg::PC_OFS, 32'h200);
		rdc(brk_pkg::STAT_OFS, 32'h1);
		run_vec(BASE, 1'b0);
		run_vec(BASE ^ (66'h300 << 54), 1'b1);
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#2000000;
		err_count++;
		finish_test();
	end
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_program();
		t_terms();
		t_excl();
		t_clear();
		t_replace();
		finish_test();
	end
endmodule
`default_nettype wire
